// File: inc/frcd_regs.svh
// opcodes, bit positions and reset values of the flash command decoder
// assumes inclusion by the decoder only
// Notes on behaviour
// - Opcode 71 takes a register address of three or four bytes by the address length, then one data byte.
// - The clear-failure command resets the erase failure flag bit 5 and program failure flag bit 6.
// - The clear-failure command is one byte, opcode 30 or 82, and a config input can disable it.
// - Opcode B7 sets the address length bit so later opcode 71 commands use four address bytes.
// - Opcode B8 clears the address length bit so later opcode 71 commands use three address bytes.
// - Opcode 41 returns the volatile learning pattern with no address.
// - Opcode 43 plus one byte stores the nonvolatile learning pattern after write enable.
// - Opcode 4A plus one byte stores only the volatile learning pattern after write enable.
// - Opcode 15 plus a stream of bytes loads the boot pattern register after write enable.
// - Opcode 19 with three or 18 with four address bytes returns that unit's ecc status.
// - Opcode 1B clears ecc status bits 4 and 3 and pulses the ecc_clear output for one clk.
// - Opcode 5B starts an integrity check over the host supplied range.
// - Opcode 06 sets the write enable latch that write type commands need.
`ifndef FRCD_REGS_SVH
`define FRCD_REGS_SVH
`define FRCD_OP_WREN       8'h06
`define FRCD_OP_REGWR      8'h71
`define FRCD_OP_CLRFAIL_A  8'h30
`define FRCD_OP_CLRFAIL_B  8'h82
`define FRCD_OP_WIDE_ON    8'hb7
`define FRCD_OP_WIDE_OFF   8'hb8
`define FRCD_OP_DLP_RD     8'h41
`define FRCD_OP_DLP_PGM    8'h43
`define FRCD_OP_DLP_WR     8'h4a
`define FRCD_OP_BOOT_WR    8'h15
`define FRCD_OP_ECC_RD3    8'h19
`define FRCD_OP_ECC_RD4    8'h18
`define FRCD_OP_ECC_CLR    8'h1b
`define FRCD_OP_CRC        8'h5b
`define FRCD_STS1_EFAIL    5
`define FRCD_STS1_PFAIL    6
`define FRCD_CFG2_WIDE     7
`define FRCD_ECC_TWO_BIT   4
`define FRCD_ECC_ONE_BIT   3
`define FRCD_CRC_BYTES     4'h8
`define FRCD_CRC_HALF      4'h4
`define FRCD_RST_DLP       8'h00
`define FRCD_RST_BOOT      32'h0000_0000
`endif

// File: inc/frcd_pkg.sv
// types of the flash command decoder
// assumes frcd_regs.svh on the include path
package frcd_pkg;
	typedef enum logic [1:0] {
		ph_idle   = 2'b00,
		ph_cmd    = 2'b01,
		ph_ignore = 2'b10
	} frcd_phase_type;

	typedef struct packed {
		logic           cs_s1, cs_s2, cs_d;
		logic           sclk_s1, sclk_s2, sclk_d;
		logic           mosi_s1, mosi_s2;
		frcd_phase_type phase;
		logic [2:0]     bitcnt;
		logic [3:0]     bytecnt;
		logic [7:0]     shreg, opcode, data, txsh;
		logic [31:0]    addr, crc_lo, boot_sh, boot;
		logic           done, tx_on, miso, miso_en_n;
		logic           wel, efail, pfail, wide, ecc2, ecc1;
		logic [7:0]     dlp_v, dlp_nv;
		logic           ecc_clr, regwr_valid, eccrd_req, ecc_pend, crc_start;
	} frcd_state_type;
endpackage : frcd_pkg

// File: rtl/frcd_decoder.sv
// command decoder for register, learning pattern, boot, ecc and crc commands of a serial flash
// assumes spi mode 0 pins from the host, far slower than clk; flag set inputs are on clk
`timescale 1ns/1ps
`include "frcd_regs.svh"
module frcd_decoder (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        cs_n,
	input  wire logic        sclk,
	input  wire logic        mosi,
	output logic             miso,
	output logic             miso_en_n,
	input  wire logic        clrfail_disable,
	input  wire logic        erase_fail_set,
	input  wire logic        pgm_fail_set,
	input  wire logic        ecc_two_set,
	input  wire logic        ecc_one_set,
	input  wire logic [7:0]  ecc_rd_status,
	output logic [7:0]       status_one,
	output logic [7:0]       config_two,
	output logic [7:0]       ecc_status,
	output logic             ecc_clear,
	output logic             write_enable,
	output logic [7:0]       dlp_volatile,
	output logic [7:0]       dlp_nonvolatile,
	output logic [31:0]      boot_pattern,
	output logic             regwr_valid,
	output logic [31:0]      regwr_addr,
	output logic [7:0]       regwr_data,
	output logic             eccrd_req,
	output logic [31:0]      eccrd_addr,
	output logic             crc_start,
	output logic [31:0]      crc_start_addr,
	output logic [31:0]      crc_end_addr
);
	import frcd_pkg::*;

	frcd_state_type s_reg, s_next;

	// ----------------------------------------
	// decode helpers
	// ----------------------------------------
	function automatic logic frcd_known(input logic [7:0] op);
		case (op)
			`FRCD_OP_WREN, `FRCD_OP_REGWR, `FRCD_OP_CLRFAIL_A, `FRCD_OP_CLRFAIL_B,
			`FRCD_OP_WIDE_ON, `FRCD_OP_WIDE_OFF, `FRCD_OP_DLP_RD, `FRCD_OP_DLP_PGM,
			`FRCD_OP_DLP_WR, `FRCD_OP_BOOT_WR, `FRCD_OP_ECC_RD3, `FRCD_OP_ECC_RD4,
			`FRCD_OP_ECC_CLR, `FRCD_OP_CRC: frcd_known = 1'b1;
			default: frcd_known = 1'b0;
		endcase
	endfunction : frcd_known

	// address bytes that follow the opcode
	function automatic logic [3:0] frcd_addr_bytes(input logic [7:0] op, input logic wide);
		case (op)
			`FRCD_OP_REGWR:   frcd_addr_bytes = wide ? 4'h4 : 4'h3;
			`FRCD_OP_ECC_RD3: frcd_addr_bytes = 4'h3;
			`FRCD_OP_ECC_RD4: frcd_addr_bytes = 4'h4;
			`FRCD_OP_CRC:     frcd_addr_bytes = `FRCD_CRC_BYTES;
			default:          frcd_addr_bytes = 4'h0;
		endcase
	endfunction : frcd_addr_bytes

	logic       cs_rise;
	logic       cs_fall;
	logic       sclk_rise;
	logic       sclk_fall;
	logic [7:0] rx_byte;
	logic [3:0] need;
	logic       clr_fail;
	logic       clr_ecc;

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		s_next = s_reg;
		cs_rise = s_reg.cs_s2 && !s_reg.cs_d;
		cs_fall = !s_reg.cs_s2 && s_reg.cs_d;
		sclk_rise = s_reg.sclk_s2 && !s_reg.sclk_d;
		sclk_fall = !s_reg.sclk_s2 && s_reg.sclk_d;
		rx_byte = {s_reg.shreg[6:0], s_reg.mosi_s2};
		need = frcd_addr_bytes(s_reg.opcode, s_reg.wide);
		clr_fail = 1'b0;
		clr_ecc = 1'b0;
		s_next.cs_s1 = cs_n;
		s_next.cs_s2 = s_reg.cs_s1;
		s_next.cs_d = s_reg.cs_s2;
		s_next.sclk_s1 = sclk;
		s_next.sclk_s2 = s_reg.sclk_s1;
		s_next.sclk_d = s_reg.sclk_s2;
		s_next.mosi_s1 = mosi;
		s_next.mosi_s2 = s_reg.mosi_s1;
		s_next.ecc_clr = 1'b0;
		s_next.regwr_valid = 1'b0;
		s_next.eccrd_req = 1'b0;
		s_next.ecc_pend = 1'b0;
		s_next.crc_start = 1'b0;
		// status is taken in the clk in which the eccrd_req pulse is high
		if (s_reg.ecc_pend) begin
			s_next.txsh = ecc_rd_status;
		end
		if (cs_fall) begin
			s_next.phase = ph_cmd;
			s_next.bitcnt = 3'h0;
			s_next.bytecnt = 4'h0;
			s_next.done = 1'b0;
			s_next.tx_on = 1'b0;
		end else if (cs_rise) begin
			s_next.phase = ph_idle;
			s_next.tx_on = 1'b0;
			s_next.miso_en_n = 1'b1;
			// commands act only when their last byte came in before deselect
			if (s_reg.phase == ph_cmd && s_reg.done) begin
				case (s_reg.opcode)
					`FRCD_OP_WREN: s_next.wel = 1'b1;
					`FRCD_OP_CLRFAIL_A, `FRCD_OP_CLRFAIL_B: clr_fail = !clrfail_disable;
					`FRCD_OP_WIDE_ON: s_next.wide = 1'b1;
					`FRCD_OP_WIDE_OFF: s_next.wide = 1'b0;
					`FRCD_OP_ECC_CLR: begin
						clr_ecc = 1'b1;
						s_next.ecc_clr = 1'b1;
					end
					`FRCD_OP_CRC: s_next.crc_start = 1'b1;
					`FRCD_OP_REGWR: begin
						s_next.regwr_valid = s_reg.wel;
						s_next.wel = 1'b0;
					end
					`FRCD_OP_DLP_PGM: begin
						if (s_reg.wel) begin
							s_next.dlp_nv = s_reg.data;
						end
						s_next.wel = 1'b0;
					end
					`FRCD_OP_DLP_WR: begin
						if (s_reg.wel) begin
							s_next.dlp_v = s_reg.data;
						end
						s_next.wel = 1'b0;
					end
					`FRCD_OP_BOOT_WR: begin
						if (s_reg.wel) begin
							s_next.boot = s_reg.boot_sh;
						end
						s_next.wel = 1'b0;
					end
					default: s_next.wel = s_reg.wel;
				endcase
			end
		end else if (!s_reg.cs_s2) begin
			if (sclk_rise && s_reg.phase == ph_cmd) begin
				s_next.shreg = rx_byte;
				s_next.bitcnt = s_reg.bitcnt + 3'h1;
				if (s_reg.bitcnt == 3'h7) begin
					if (s_reg.bytecnt != 4'hf) begin
						s_next.bytecnt = s_reg.bytecnt + 4'h1;
					end
					if (s_reg.bytecnt == 4'h0) begin
						s_next.opcode = rx_byte;
						if (!frcd_known(rx_byte)) begin
							s_next.phase = ph_ignore;
						end
						if (frcd_addr_bytes(rx_byte, s_reg.wide) == 4'h0 && rx_byte != `FRCD_OP_DLP_PGM
							&& rx_byte != `FRCD_OP_DLP_WR && rx_byte != `FRCD_OP_BOOT_WR) begin
							s_next.done = 1'b1;
						end
						if (rx_byte == `FRCD_OP_DLP_RD) begin
							s_next.txsh = s_reg.dlp_v;
							s_next.tx_on = 1'b1;
						end
					end else begin
						s_next.data = rx_byte;
						s_next.boot_sh = {s_reg.boot_sh[23:0], rx_byte};
						if (s_reg.bytecnt <= need) begin
							s_next.addr = {s_reg.addr[23:0], rx_byte};
						end
						if (s_reg.opcode == `FRCD_OP_CRC && s_reg.bytecnt == `FRCD_CRC_HALF) begin
							s_next.crc_lo = {s_reg.addr[23:0], rx_byte};
						end
						case (s_reg.opcode)
							`FRCD_OP_REGWR: s_next.done = s_reg.done || s_reg.bytecnt == need + 4'h1;
							`FRCD_OP_CRC: s_next.done = s_reg.done || s_reg.bytecnt == need;
							`FRCD_OP_ECC_RD3, `FRCD_OP_ECC_RD4: begin
								if (s_reg.bytecnt == need) begin
									s_next.eccrd_req = 1'b1;
									s_next.ecc_pend = 1'b1;
									s_next.tx_on = 1'b1;
									s_next.done = 1'b1;
								end
							end
							`FRCD_OP_DLP_PGM, `FRCD_OP_DLP_WR: s_next.done = s_reg.done || s_reg.bytecnt == 4'h1;
							`FRCD_OP_BOOT_WR: s_next.done = 1'b1;
							default: s_next.done = s_reg.done;
						endcase
					end
				end
			end
			// output changes on the falling edge; the byte repeats while clocked
			if (sclk_fall && s_reg.tx_on) begin
				s_next.miso = s_reg.txsh[7];
				s_next.txsh = {s_reg.txsh[6:0], s_reg.txsh[7]};
				s_next.miso_en_n = 1'b0;
			end
		end
		// a hardware set in the clearing cycle wins
		s_next.efail = (s_reg.efail && !clr_fail) || erase_fail_set;
		s_next.pfail = (s_reg.pfail && !clr_fail) || pgm_fail_set;
		s_next.ecc2 = (s_reg.ecc2 && !clr_ecc) || ecc_two_set;
		s_next.ecc1 = (s_reg.ecc1 && !clr_ecc) || ecc_one_set;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s_reg <= '0;
			s_reg.cs_s1 <= 1'b1;
			s_reg.cs_s2 <= 1'b1;
			s_reg.cs_d <= 1'b1;
			s_reg.miso_en_n <= 1'b1;
			s_reg.dlp_v <= `FRCD_RST_DLP;
			s_reg.dlp_nv <= `FRCD_RST_DLP;
			s_reg.boot <= `FRCD_RST_BOOT;
		end else begin
			s_reg <= s_next;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	always_comb begin
		miso = s_reg.miso;
		miso_en_n = s_reg.miso_en_n;
		status_one = 8'h00;
		status_one[`FRCD_STS1_EFAIL] = s_reg.efail;
		status_one[`FRCD_STS1_PFAIL] = s_reg.pfail;
		status_one[0] = s_reg.wel;
		config_two = 8'h00;
		config_two[`FRCD_CFG2_WIDE] = s_reg.wide;
		ecc_status = 8'h00;
		ecc_status[`FRCD_ECC_TWO_BIT] = s_reg.ecc2;
		ecc_status[`FRCD_ECC_ONE_BIT] = s_reg.ecc1;
		ecc_clear = s_reg.ecc_clr;
		write_enable = s_reg.wel;
		dlp_volatile = s_reg.dlp_v;
		dlp_nonvolatile = s_reg.dlp_nv;
		boot_pattern = s_reg.boot;
		regwr_valid = s_reg.regwr_valid;
		regwr_addr = s_reg.addr;
		regwr_data = s_reg.data;
		eccrd_req = s_reg.eccrd_req;
		eccrd_addr = s_reg.addr;
		crc_start = s_reg.crc_start;
		crc_start_addr = s_reg.crc_lo;
		crc_end_addr = s_reg.addr;
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	a_wide_enter: assert property (cs_rise && s_reg.phase == ph_cmd && s_reg.done
		&& s_reg.opcode == `FRCD_OP_WIDE_ON |=> config_two[`FRCD_CFG2_WIDE]) else $error("wide mode not entered");
	a_wide_exit: assert property (cs_rise && s_reg.phase == ph_cmd && s_reg.done
		&& s_reg.opcode == `FRCD_OP_WIDE_OFF |=> !config_two[`FRCD_CFG2_WIDE]) else $error("wide mode not left");
	a_fail_clear: assert property (cs_rise && s_reg.phase == ph_cmd && s_reg.done && !clrfail_disable
		&& s_reg.opcode == `FRCD_OP_CLRFAIL_B && !erase_fail_set && !pgm_fail_set
		|=> status_one[6:5] == 2'b00) else $error("failure flags not cleared");
	a_fail_keep: assert property (clrfail_disable && !rst |=> $stable(s_reg.efail) || s_reg.efail) else $error("disabled clear acted");
	a_regwr_gate: assert property (regwr_valid |-> $past(s_reg.wel) && !write_enable) else $error("register write without latch");
	a_dlp_read: assert property (sclk_rise && s_reg.phase == ph_cmd && s_reg.bitcnt == 3'h7 && s_reg.bytecnt == 4'h0
		&& rx_byte == `FRCD_OP_DLP_RD |=> s_reg.txsh == s_reg.dlp_v && s_reg.tx_on) else $error("learning pattern not loaded");
	a_ecc_status: assert property (eccrd_req |=> s_reg.txsh == $past(ecc_rd_status)) else $error("ecc status not loaded");
	a_ecc_clear: assert property (cs_rise && s_reg.phase == ph_cmd && s_reg.done && s_reg.opcode == `FRCD_OP_ECC_CLR
		&& !ecc_two_set && !ecc_one_set |=> ecc_clear && ecc_status == 8'h00 ##1 !ecc_clear) else $error("ecc clear wrong");
	a_ignore_unk: assert property (s_reg.phase == ph_ignore |-> miso_en_n && !s_reg.tx_on) else $error("unknown opcode answered");
	a_set_wins: assert property (erase_fail_set |=> status_one[`FRCD_STS1_EFAIL]) else $error("erase failure set lost");
endmodule : frcd_decoder

// File: testbench/frcd_spi_host.sv
// spi mode 0 host model that drives the decoder's serial pins
// assumes clk from the bench; the bench fills tx and calls frame
`timescale 1ns/1ps
module frcd_spi_host (
	input  wire logic clk,
	output logic      cs_n,
	output logic      sclk,
	output logic      mosi,
	input  wire logic miso,
	input  wire logic miso_en_n
);
	logic [7:0] tx [0:15];
	logic [7:0] rx [0:15];
	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		mosi = 1'b0;
	end
	// ----------------------------------------
	// one frame: n whole bytes, msb first
	// ----------------------------------------
	// sclk 200 ns period, stands still low outside frames
	task automatic frame(input int n);
		int i;
		int j;
		@(negedge clk);
		cs_n = 1'b0;
		repeat (4) @(negedge clk);
		for (i = 0; i < n; i++) begin
			for (j = 7; j >= 0; j--) begin
				mosi = tx[i][j];
				repeat (4) @(negedge clk);
				rx[i][j] = (miso_en_n === 1'b0) ? miso : 1'bx;
				sclk = 1'b1;
				repeat (4) @(negedge clk);
				sclk = 1'b0;
			end
		end
		repeat (4) @(negedge clk);
		cs_n = 1'b1;
		// idle line no longer holds the last bit
		mosi = ~mosi;
		repeat (16) @(negedge clk);
	endtask : frame
endmodule : frcd_spi_host

// File: testbench/testbench.sv
// self-checking bench of the flash command decoder
// assumes frcd_spi_host as the serial host
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin miscompares++; \
	$display("mismatch at %0t got %h exp %h", $time, (g), (e)); end end
module testbench;
	import frcd_pkg::*;
	logic clk, rst, cs_n, sclk, mosi, miso, miso_en_n, clrfail_disable;
	logic erase_fail_set, pgm_fail_set, ecc_two_set, ecc_one_set, ecc_clear, write_enable;
	logic regwr_valid, eccrd_req, crc_start;
	logic [7:0] ecc_rd_status, status_one, config_two, ecc_status, dlp_volatile, dlp_nonvolatile, regwr_data;
	logic [31:0] boot_pattern, regwr_addr, eccrd_addr, crc_start_addr, crc_end_addr;
	logic [63:0] exp_q [$];
	logic [63:0] msk_q [$];
	logic [63:0] got, m;
	logic [7:0] b [0:8];
	int miscompares, tests_run, clr_cnt, i;
	int seed = 32'h3baa;
	frcd_decoder u_frcd_decoder (.clk(clk), .rst(rst), .cs_n(cs_n), .sclk(sclk), .mosi(mosi), .miso(miso),
		.miso_en_n(miso_en_n), .clrfail_disable(clrfail_disable), .erase_fail_set(erase_fail_set),
		.pgm_fail_set(pgm_fail_set), .ecc_two_set(ecc_two_set), .ecc_one_set(ecc_one_set),
		.ecc_rd_status(ecc_rd_status), .status_one(status_one), .config_two(config_two),
		.ecc_status(ecc_status), .ecc_clear(ecc_clear), .write_enable(write_enable),
		.dlp_volatile(dlp_volatile), .dlp_nonvolatile(dlp_nonvolatile), .boot_pattern(boot_pattern),
		.regwr_valid(regwr_valid), .regwr_addr(regwr_addr), .regwr_data(regwr_data),
		.eccrd_req(eccrd_req), .eccrd_addr(eccrd_addr), .crc_start(crc_start),
		.crc_start_addr(crc_start_addr), .crc_end_addr(crc_end_addr));
	frcd_spi_host u_host (.clk(clk), .cs_n(cs_n), .sclk(sclk), .mosi(mosi), .miso(miso), .miso_en_n(miso_en_n));
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : print_verdict
	task automatic send(input int n);
		for (int k = 0; k < n; k++)
			u_host.tx[k] = b[k];
		u_host.frame(n);
	endtask : send
	task automatic op1(input logic [7:0] op);
		b[0] = op;
		send(1);
	endtask : op1
	task automatic rnd_bytes();
		for (int k = 1; k < 9; k++)
			b[k] = 8'($random(seed));
	endtask : rnd_bytes
	task automatic note(input logic [63:0] e, input logic [63:0] mk);
		exp_q.push_back(e & mk);
		msk_q.push_back(mk);
	endtask : note
	task automatic set_flags();
		@(negedge clk);
		{erase_fail_set, pgm_fail_set, ecc_two_set, ecc_one_set} = 4'hf;
		@(negedge clk);
		{erase_fail_set, pgm_fail_set, ecc_two_set, ecc_one_set} = 4'h0;
	endtask : set_flags
	// ----------------------------------------
	// watcher: every register write, ecc read or crc pulse takes the oldest note
	// ----------------------------------------
	// looks on the falling edge, where the registered pulses have settled
	always @(negedge clk) begin
		if (!rst && ecc_clear === 1'b1)
			clr_cnt++;
		if (!rst && (regwr_valid === 1'b1 || eccrd_req === 1'b1 || crc_start === 1'b1)) begin
			got = crc_start ? {crc_start_addr, crc_end_addr} :
				eccrd_req ? {eccrd_addr, 32'h0} : {regwr_addr, 24'h0, regwr_data};
			if (exp_q.size() == 0) begin
				`CHK(got, 64'hx)
			end else begin
				m = msk_q.pop_front();
				`CHK(got & m, exp_q.pop_front())
			end
		end
	end
	initial begin
		repeat (60000) @(posedge clk);
		miscompares++;
		print_verdict();
	end
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		rst = 1'b1;
		{clrfail_disable, erase_fail_set, pgm_fail_set, ecc_two_set, ecc_one_set} = 5'h0;
		ecc_rd_status = 8'h00;
		repeat (12) @(negedge clk);
		rst = 1'b0;
		repeat (4) @(negedge clk);
		`CHK({status_one, config_two, ecc_status, dlp_volatile, miso_en_n}, 33'h1)
		rnd_bytes();
		b[0] = 8'h71;
		send(5); // no latch, no pulse expected
		`CHK(write_enable, 1'b0)
		op1(8'h06);
		`CHK(status_one, 8'h01)
		b[0] = 8'h71;
		note({8'h0, b[1], b[2], b[3], 24'h0, b[4]}, 64'h00ffffff_ffffffff);
		send(5);
		`CHK(write_enable, 1'b0)
		op1(8'hb7);
		`CHK(config_two, 8'h80)
		rnd_bytes();
		op1(8'h06);
		b[0] = 8'h71;
		note({b[1], b[2], b[3], b[4], 24'h0, b[5]}, 64'hffffffff_ffffffff);
		send(6);
		op1(8'hb8);
		`CHK(config_two, 8'h00)
		op1(8'h06);
		b[0] = 8'h43;
		send(2);
		op1(8'h06);
		b[0] = 8'h4a;
		b[2] = b[1];
		b[1] = ~b[2];
		send(2);
		`CHK({dlp_nonvolatile, dlp_volatile}, {b[2], ~b[2]})
		b[0] = 8'h4a;
		b[1] = b[2];
		send(2); // latch clear, pattern stays
		`CHK(dlp_volatile, ~b[2])
		b[0] = 8'h41;
		b[1] = 8'h00;
		send(2);
		`CHK(u_host.rx[1], ~b[2])
		rnd_bytes();
		op1(8'h06);
		b[0] = 8'h15;
		send(6);
		`CHK(boot_pattern, {b[2], b[3], b[4], b[5]})
		for (i = 0; i < 2; i++) begin
			rnd_bytes();
			ecc_rd_status = b[8];
			b[0] = i ? 8'h18 : 8'h19;
			note(i ? {b[1], b[2], b[3], b[4], 32'h0} : {8'h0, b[1], b[2], b[3], 32'h0},
				i ? 64'hffffffff_00000000 : 64'h00ffffff_00000000);
			b[4 - i + i * 4] = i ? b[4] : 8'h00;
			send(5 + i);
			`CHK(u_host.rx[4 + i], b[8])
		end
		for (i = 0; i < 3; i++) begin
			clrfail_disable = (i == 2);
			set_flags();
			`CHK(status_one, 8'h60)
			op1(i == 1 ? 8'h82 : 8'h30);
			`CHK(status_one, (i == 2) ? 8'h60 : 8'h00)
		end
		`CHK(ecc_status, 8'h18)
		op1(8'h1b);
		`CHK({ecc_status, 8'(clr_cnt)}, 16'h0001)
		rnd_bytes();
		b[0] = 8'h5b;
		note({b[1], b[2], b[3], b[4], b[5], b[6], b[7], b[8]}, 64'hffffffff_ffffffff);
		send(9);
		b[0] = 8'hc3;
		b[1] = 8'hb7;
		send(2);
		`CHK(config_two, 8'h00)
		`CHK(exp_q.size(), 0)
		print_verdict();
	end
endmodule : testbench
